// [design/synth1_cfg_pkg.sv]
/*
 Package for the first synthesizer configuration register bank:
 register offsets, field positions, field widths, reset values and codes.
 Assumes byte-wide registers addressed by a plain 8-bit register index.
*/
package synth1_cfg_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CONTROL_B = 8'h39;
  localparam logic [7:0] OFS_INT_DIV_HIGH = 8'h3a;
  localparam logic [7:0] OFS_INT_DIV_LOW = 8'h3b;
  localparam logic [7:0] OFS_NUM_TOP = 8'h3c;
  localparam logic [7:0] OFS_NUM_MID = 8'h3d;
  localparam logic [7:0] OFS_NUM_LOW = 8'h3e;
  localparam logic [7:0] OFS_DEN_TOP = 8'h3f;
  localparam logic [7:0] OFS_DEN_MID = 8'h40;
  localparam logic [7:0] OFS_DEN_LOW = 8'h41;
  localparam logic [7:0] OFS_MOD_CTRL = 8'h42;
  localparam logic [7:0] OFS_FILTER_R2 = 8'h43;
  localparam int NUM_REGS = 11;

  // ==========================================================
  // Field positions and writable masks
  localparam int POS_SPARE = 5;
  localparam int POS_DOUBLER = 4;
  localparam int POS_DITHER = 2;
  localparam int POS_ORDER = 0;
  localparam logic [7:0] MASK_CONTROL_B = 8'h3f;
  localparam logic [7:0] MASK_NIBBLE = 8'h0f;
  localparam logic [7:0] MASK_SIX = 8'h3f;
  localparam logic [7:0] MASK_BYTE = 8'hff;

  // ==========================================================
  // Reset values
  localparam logic RST_SPARE = 1'b0;
  localparam logic RST_DOUBLER = 1'b1;
  localparam logic [3:0] RST_PUMP = 4'h8;
  localparam logic [7:0] RST_INT_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_INT_DIV_LOW = 8'h66;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] RST_DITHER = 2'h3;
  localparam logic [1:0] RST_ORDER = 2'h0;
  localparam logic [7:0] RST_FILTER_R2 = 8'h24;

  // ==========================================================
  // Codes
  localparam logic [11:0] INT_DIV_MIN_RATIO = 12'h001;
  localparam logic [3:0] PUMP_CODE_MAX = 4'h8;
  localparam logic [1:0] DITHER_WEAK = 2'h0;
  localparam logic [1:0] DITHER_MEDIUM = 2'h1;
  localparam logic [1:0] DITHER_STRONG = 2'h2;
  localparam logic [1:0] DITHER_OFF = 2'h3;
  localparam logic [1:0] ORDER_INTEGER = 2'h0;
endpackage : synth1_cfg_pkg

// [design/cfg_byte_reg.sv]
/*
 One byte-wide configuration register with a writable-bit mask.
 Assumes a synchronised active-low reset; bits outside the mask hold zero.
*/
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] value
);
  typedef struct packed {
    logic [7:0] val;
  } reg_state_t;

  reg_state_t state_q;
  reg_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (wr_en) begin
      state_d.val = wr_data & MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= '{val: RESET_VAL & MASK};
    end else begin
      state_q <= state_d;
    end
  end

  assign value = state_q.val;
endmodule : cfg_byte_reg

// [design/synth1_config_register_bank.sv]
/*
 Configuration register bank of the first fractional-N synthesizer.
 Assumes a plain register port on mclk: one-cycle read or write strobes,
 read data in the cycle after a read. Decoded settings leave on flops.
*/
// Decided for this implementation: the plain strobed port.
// Behaviour
// RULE_01 - Bit 4 of control register enables primary reference doubler, resets to one.
// RULE_02 - Bits 3:0 hold charge pump code, reset 0x8; codes 1-7 and 8 valid.
// RULE_03 - 12-bit integer divider from two registers; 0 and 1 both mean ratio one.
// RULE_04 - Integer divider resets to low byte 0x66, high nibble zero: ratio 102.
// RULE_05 - 22-bit fractional numerator spans three registers, all reset to zero.
// RULE_06 - 22-bit fractional denominator spans three registers, all reset to zero.
// RULE_07 - Dither field bits 3:2: weak, medium, strong, off; resets to off.
// RULE_08 - Order field bits 1:0: integer, first, second, third; resets to integer.
// RULE_09 - Six-bit loop filter R2 code in bits 5:0, resets to 0x24.
// RULE_10 - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
module synth1_config_register_bank (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic primary_ref_doubler_en,
  output logic [3:0] synth1_pump_current_code,
  output logic synth1_pump_code_valid,
  output logic [11:0] synth1_int_divider,
  output logic [11:0] synth1_int_ratio,
  output logic [21:0] synth1_frac_numerator,
  output logic [21:0] synth1_frac_denominator,
  output logic [1:0] synth1_dither_select,
  output logic synth1_dither_on,
  output logic [1:0] synth1_modulator_order,
  output logic synth1_fractional_mode,
  output logic [5:0] synth1_filter_resistor_code
);
  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_q[1];

  // ==========================================================
  // Register array
  localparam logic [7:0] OFS [synth1_cfg_pkg::NUM_REGS] = '{
    synth1_cfg_pkg::OFS_CONTROL_B, synth1_cfg_pkg::OFS_INT_DIV_HIGH,
    synth1_cfg_pkg::OFS_INT_DIV_LOW, synth1_cfg_pkg::OFS_NUM_TOP,
    synth1_cfg_pkg::OFS_NUM_MID, synth1_cfg_pkg::OFS_NUM_LOW,
    synth1_cfg_pkg::OFS_DEN_TOP, synth1_cfg_pkg::OFS_DEN_MID,
    synth1_cfg_pkg::OFS_DEN_LOW, synth1_cfg_pkg::OFS_MOD_CTRL,
    synth1_cfg_pkg::OFS_FILTER_R2};
  // Reserved bits are masked off at write time [RULE_10]
  localparam logic [7:0] MASKS [synth1_cfg_pkg::NUM_REGS] = '{
    synth1_cfg_pkg::MASK_CONTROL_B, synth1_cfg_pkg::MASK_NIBBLE,
    synth1_cfg_pkg::MASK_BYTE, synth1_cfg_pkg::MASK_SIX,
    synth1_cfg_pkg::MASK_BYTE, synth1_cfg_pkg::MASK_BYTE,
    synth1_cfg_pkg::MASK_SIX, synth1_cfg_pkg::MASK_BYTE,
    synth1_cfg_pkg::MASK_BYTE, synth1_cfg_pkg::MASK_NIBBLE,
    synth1_cfg_pkg::MASK_SIX};
  localparam logic [7:0] RSTS [synth1_cfg_pkg::NUM_REGS] = '{
    {2'h0, synth1_cfg_pkg::RST_SPARE, synth1_cfg_pkg::RST_DOUBLER,
     synth1_cfg_pkg::RST_PUMP}, // [RULE_01] [RULE_02]
    synth1_cfg_pkg::RST_INT_DIV_HIGH, synth1_cfg_pkg::RST_INT_DIV_LOW, // [RULE_04]
    synth1_cfg_pkg::RST_ZERO, synth1_cfg_pkg::RST_ZERO, synth1_cfg_pkg::RST_ZERO, // [RULE_05]
    synth1_cfg_pkg::RST_ZERO, synth1_cfg_pkg::RST_ZERO, synth1_cfg_pkg::RST_ZERO, // [RULE_06]
    {4'h0, synth1_cfg_pkg::RST_DITHER, synth1_cfg_pkg::RST_ORDER}, // [RULE_07] [RULE_08]
    synth1_cfg_pkg::RST_FILTER_R2}; // [RULE_09]

  logic [7:0] regs [synth1_cfg_pkg::NUM_REGS];

  for (genvar i = 0; i < synth1_cfg_pkg::NUM_REGS; i++) begin : g_reg
    cfg_byte_reg #(
      .MASK(MASKS[i]),
      .RESET_VAL(RSTS[i])
    ) u_reg (
      .mclk(mclk),
      .rst_sync_n(rst_sync_n),
      .wr_en(reg_wr && (reg_addr == OFS[i])),
      .wr_data(reg_wdata),
      .value(regs[i])
    );
  end

  // ==========================================================
  // Read path and decoded outputs
  typedef struct packed {
    logic [7:0] rdata;
    logic doubler;
    logic [3:0] pump;
    logic pump_valid;
    logic [11:0] int_div;
    logic [11:0] int_ratio;
    logic [21:0] num;
    logic [21:0] den;
    logic [1:0] dither;
    logic dither_on;
    logic [1:0] order;
    logic frac_mode;
    logic [5:0] r2;
  } bank_state_t;

  bank_state_t state_q;
  bank_state_t state_d;
  logic [11:0] int_div_w;

  assign int_div_w = {regs[1][3:0], regs[2]}; // [RULE_03]

  always_comb begin
    state_d = state_q;
    // Unmapped addresses read zero
    state_d.rdata = 8'h00;
    if (reg_rd) begin
      for (int k = 0; k < synth1_cfg_pkg::NUM_REGS; k++) begin
        if (reg_addr == OFS[k]) begin
          state_d.rdata = regs[k]; // [RULE_10]
        end
      end
    end
    state_d.doubler = regs[0][synth1_cfg_pkg::POS_DOUBLER]; // [RULE_01]
    state_d.pump = regs[0][3:0]; // [RULE_02]
    // Code 0 and codes above 8 have no listed current
    state_d.pump_valid = (regs[0][3:0] != 4'h0) &&
                         (regs[0][3:0] <= synth1_cfg_pkg::PUMP_CODE_MAX); // [RULE_02]
    state_d.int_div = int_div_w; // [RULE_03]
    state_d.int_ratio = (int_div_w == 12'h000) ? synth1_cfg_pkg::INT_DIV_MIN_RATIO
                                               : int_div_w; // [RULE_03]
    state_d.num = {regs[3][5:0], regs[4], regs[5]}; // [RULE_05]
    state_d.den = {regs[6][5:0], regs[7], regs[8]}; // [RULE_06]
    state_d.dither = regs[9][synth1_cfg_pkg::POS_DITHER +: 2]; // [RULE_07]
    state_d.dither_on = regs[9][synth1_cfg_pkg::POS_DITHER +: 2] != synth1_cfg_pkg::DITHER_OFF; // [RULE_07]
    state_d.order = regs[9][synth1_cfg_pkg::POS_ORDER +: 2]; // [RULE_08]
    state_d.frac_mode = regs[9][synth1_cfg_pkg::POS_ORDER +: 2] != synth1_cfg_pkg::ORDER_INTEGER; // [RULE_08]
    state_d.r2 = regs[10][5:0]; // [RULE_09]
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= '{rdata: 8'h00,
                   doubler: synth1_cfg_pkg::RST_DOUBLER,
                   pump: synth1_cfg_pkg::RST_PUMP,
                   pump_valid: 1'b1,
                   int_div: {synth1_cfg_pkg::RST_INT_DIV_HIGH[3:0], synth1_cfg_pkg::RST_INT_DIV_LOW},
                   int_ratio: {synth1_cfg_pkg::RST_INT_DIV_HIGH[3:0], synth1_cfg_pkg::RST_INT_DIV_LOW},
                   num: 22'h0,
                   den: 22'h0,
                   dither: synth1_cfg_pkg::RST_DITHER,
                   dither_on: 1'b0,
                   order: synth1_cfg_pkg::RST_ORDER,
                   frac_mode: 1'b0,
                   r2: synth1_cfg_pkg::RST_FILTER_R2[5:0]};
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata = state_q.rdata;
  assign primary_ref_doubler_en = state_q.doubler;
  assign synth1_pump_current_code = state_q.pump;
  assign synth1_pump_code_valid = state_q.pump_valid;
  assign synth1_int_divider = state_q.int_div;
  assign synth1_int_ratio = state_q.int_ratio;
  assign synth1_frac_numerator = state_q.num;
  assign synth1_frac_denominator = state_q.den;
  assign synth1_dither_select = state_q.dither;
  assign synth1_dither_on = state_q.dither_on;
  assign synth1_modulator_order = state_q.order;
  assign synth1_fractional_mode = state_q.frac_mode;
  assign synth1_filter_resistor_code = state_q.r2;
endmodule : synth1_config_register_bank

// [test/synth1_cfg_assertions.sv]
/* Port checker for the synth1 register bank.
   Assumes the bank's top ports; bound in after the module. */
`timescale 1ns/1ps
module synth1_cfg_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic primary_ref_doubler_en,
  input wire logic [3:0] synth1_pump_current_code,
  input wire logic [11:0] synth1_int_divider,
  input wire logic [11:0] synth1_int_ratio,
  input wire logic [21:0] synth1_frac_numerator,
  input wire logic [21:0] synth1_frac_denominator,
  input wire logic [1:0] synth1_dither_select,
  input wire logic synth1_dither_on,
  input wire logic [1:0] synth1_modulator_order,
  input wire logic synth1_fractional_mode,
  input wire logic [5:0] synth1_filter_resistor_code
);
  // ==========================================================
  // Decoded outputs lag a write by two edges
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_ctrl;
    reg_wr && reg_addr == 8'h39 |-> ##2
      {primary_ref_doubler_en, synth1_pump_current_code} == $past(reg_wdata[4:0], 2);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control byte not decoded");
  property p_div; reg_wr && reg_addr == 8'h3b |-> ##2 synth1_int_divider[7:0] == $past(reg_wdata, 2); endproperty
  a_div: assert property (p_div) else $error("divider low byte wrong");
  property p_ratio; synth1_int_ratio == ((synth1_int_divider < 12'h002) ? 12'h001 : synth1_int_divider); endproperty
  a_ratio: assert property (p_ratio) else $error("divider ratio wrong");
  property p_num;
    reg_wr && reg_addr == 8'h3c |-> ##2 synth1_frac_numerator[21:16] == $past(reg_wdata[5:0], 2);
  endproperty
  a_num: assert property (p_num) else $error("numerator top wrong");
  property p_den; reg_wr && reg_addr == 8'h41 |-> ##2 synth1_frac_denominator[7:0] == $past(reg_wdata, 2); endproperty
  a_den: assert property (p_den) else $error("denominator low wrong");
  property p_mod;
    reg_wr && reg_addr == 8'h42 |-> ##2
      {synth1_dither_select, synth1_modulator_order} == $past(reg_wdata[3:0], 2);
  endproperty
  a_mod: assert property (p_mod) else $error("modulator control wrong");
  property p_flags;
    synth1_dither_on == (synth1_dither_select != 2'h3) && synth1_fractional_mode == (synth1_modulator_order != 2'h0);
  endproperty
  a_flags: assert property (p_flags) else $error("mode flags wrong");
  property p_r2;
    reg_wr && reg_addr == 8'h43 |-> ##2 synth1_filter_resistor_code == $past(reg_wdata[5:0], 2);
  endproperty
  a_r2: assert property (p_r2) else $error("filter code wrong");
  c_rd: cover property (reg_rd ##1 reg_rdata != 8'h00);
  c_frac: cover property (synth1_fractional_mode && synth1_dither_on);
  c_one: cover property (synth1_int_divider == 12'h000);
endmodule : synth1_cfg_checker

bind synth1_config_register_bank synth1_cfg_checker u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .primary_ref_doubler_en(primary_ref_doubler_en), .synth1_pump_current_code(synth1_pump_current_code),
  .synth1_int_divider(synth1_int_divider), .synth1_int_ratio(synth1_int_ratio),
  .synth1_frac_numerator(synth1_frac_numerator), .synth1_frac_denominator(synth1_frac_denominator),
  .synth1_dither_select(synth1_dither_select), .synth1_dither_on(synth1_dither_on),
  .synth1_modulator_order(synth1_modulator_order), .synth1_fractional_mode(synth1_fractional_mode),
  .synth1_filter_resistor_code(synth1_filter_resistor_code));

// [test/tb_synth1_config_register_bank.sv]
/* Self-checking bench for the synth1 register bank.
   Assumes a 25 MHz clock and the plain one-cycle register port. */
`timescale 1ns/1ps
module tb_synth1_config_register_bank;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rdata;
  logic dbl, pv, don, fm;
  logic [3:0] pump;
  logic [11:0] ndiv, ratio;
  logic [21:0] num, den;
  logic [1:0] dth, ord;
  logic [5:0] r2;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] rst_v [11] = '{8'h18, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h24};
  logic [7:0] msk [11] = '{8'h3f, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h0f, 8'h3f};

  synth1_config_register_bank u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .primary_ref_doubler_en(dbl),
    .synth1_pump_current_code(pump), .synth1_pump_code_valid(pv), .synth1_int_divider(ndiv),
    .synth1_int_ratio(ratio), .synth1_frac_numerator(num), .synth1_frac_denominator(den),
    .synth1_dither_select(dth), .synth1_dither_on(don), .synth1_modulator_order(ord),
    .synth1_fractional_mode(fm), .synth1_filter_resistor_code(r2));

  always #20 mclk = ~mclk;

  // ==========================================================
  // Bus and compare helpers
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check($sformatf("rdata %h", a), exp, rdata);
  endtask : rd
  // Outputs settle one edge after the register itself
  task settle;
    @(posedge mclk);
    #1;
  endtask : settle

  // ==========================================================
  // Scenarios
  task t_reset;
    for (int i = 0; i < 11; i++) rd(8'h39 + 8'(i), rst_v[i]);
    rd(8'h44, 8'h00);
    check("doubler", 1, dbl);
    check("pump", 8, pump);
    check("pump valid", 1, pv);
    check("ratio", 102, ratio);
    check("ndiv", 12'h066, ndiv);
    check("num", 0, num);
    check("den", 0, den);
    check("modes", 6'h30, {dth, ord, don, fm});
    check("r2", 6'h24, r2);
    $display("test reset done");
  endtask : t_reset
  task t_mask;
    for (int i = 0; i < 12; i++) wr(8'h39 + 8'(i), 8'hff);
    for (int i = 0; i < 11; i++) rd(8'h39 + 8'(i), msk[i]);
    rd(8'h44, 8'h00);
    check("divider", 12'hfff, ratio);
    check("ndiv", 12'hfff, ndiv);
    check("doubler set", 1, dbl);
    check("num", 22'h3fffff, num);
    check("r2", 6'h3f, r2);
    wr(8'h3a, 8'h00);
    wr(8'h3b, 8'h00);
    settle();
    check("ratio zero", 1, ratio);
    check("ndiv zero", 0, ndiv);
    wr(8'h3b, 8'h01);
    settle();
    check("ratio one", 1, ratio);
    wr(8'h3c, 8'h2a);
    wr(8'h3d, 8'h5a);
    wr(8'h3e, 8'hc3);
    wr(8'h3f, 8'h15);
    wr(8'h40, 8'ha5);
    wr(8'h41, 8'h3c);
    rd(8'h41, 8'h3c);
    check("num bytes", 22'h2a5ac3, num);
    check("den bytes", 22'h15a53c, den);
    // Write and read with no gap: the read sees the new byte
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= 8'h43;
    reg_wdata <= 8'h15;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check("read after write", 8'h15, rdata);
    @(posedge mclk);
    #1 check("rdata idle", 0, rdata);
    check("r2 written", 6'h15, r2);
    $display("test mask done");
  endtask : t_mask
  task t_modes;
    for (int i = 0; i < 16; i++) begin
      wr(8'h39, {3'h0, i[0], i[3:0]});
      wr(8'h42, 8'hf0 | 8'(i));
      settle();
      check("doubler pump valid", {i[0], (i >= 1 && i <= 8)}, {dbl, pv});
      check("pump code", i[3:0], pump);
      check("dither", {i[3:2], i[3:2] != 2'h3}, {dth, don});
      check("order", {i[1:0], i[1:0] != 2'h0}, {ord, fm});
    end
    $display("test modes done");
  endtask : t_modes
  // Mid-run reset must bring back every reset value
  task t_rerst;
    wr(8'h3b, 8'h12);
    settle();
    check("ndiv written", 12'h012, ndiv);
    @(posedge mclk);
    @(posedge mclk);
    rst_n <= 1'b0;
    #1 check("ndiv in reset", 12'h066, ndiv);
    check("doubler in reset", 1, dbl);
    check("rdata in reset", 0, rdata);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    $display("test rerst done");
  endtask : t_rerst

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_mask();
    t_modes();
    t_rerst();
    final_report();
  end
  // About 220 cycles expected; 2500 allowed
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
endmodule : tb_synth1_config_register_bank
